// [logic/vss_defs.vh]
// register layout, reset values and field positions of the vertical sequence bank
`ifndef VSS_DEFS_VH
`define VSS_DEFS_VH
`define VSS_BANK_ADDR 8'h14
`define VSS_HDR_ADDR_MSB 31
`define VSS_HDR_ADDR_LSB 24
`define VSS_HDR_CNT_MSB 23
`define VSS_HDR_CNT_LSB 0
`define VSS_WORDS 8
`define VSS_BANK_BITS 256
// packed reset image, word 1 at the top (bits 255:224), word 8 at the bottom
`define VSS_RESET_IMAGE {32'h1298_0026, 32'h0C0F_8002, 32'h60C0_F9A0, 32'hC243_A179, \
                         32'h8000_4C13, 32'h1A47_2600, 32'h0E84_C600, 32'h00E8_4C60}
// write-enable mask of the bank; word 8 bit 0 is unused
`define VSS_WRITE_MASK 256'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFE
// field start positions (msb) in the packed 256-bit image
`define VSS_SEQ0_BASE 255
`define VSS_SEQ1_BASE 170
`define VSS_SEQ2_BASE 85
`define VSS_LEN_W 9
`define VSS_SEQ_BITS 85
`endif

// [logic/vss_shadow_mem.v]
// eight-word memory for the pending (written but not yet applied) bank image
`timescale 1ns/1ps
module vss_shadow_mem #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire clkEn,
  input wire wrEn,
  input wire [AW-1:0] wrAddr,
  input wire [WIDTH-1:0] wrData,
  input wire [AW-1:0] rdAddr,
  output reg [WIDTH-1:0] rdData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // registered read keeps the output flop-driven
  always @(posedge clk) begin
    if (clkEn) begin
      if (wrEn) begin
        mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
    end
  end
endmodule // vss_shadow_mem

// [logic/vss_vertical_sequence_regs.v]
// vertical sequence system bank: word loader, sync-held update and phase generators
//
// Overview of operation
// R1 - bank is vertical-sync synchronous after reset
// R2 - new values apply at next sync falling edge
// R3 - async update select applies writes immediately
// R4 - header top byte carries bank address 0x14
// R5 - header low 24 bits count words; zero=all
// R6 - sequence 0 length word1 31:23, reset 37
// R7 - sequence 0 polarities bits 22:19, 0,0,1,1
// R8 - two 9-bit toggles per phase, packed
// R9 - fields pack contiguously across word boundaries
// R10 - sequence 1 length word3 10:2, reset 104
// R11 - sequence 1 phase 3/4 polarity word4 31:30
// R12 - sequence 2 length word6 21:13, polarities 12:9
// R13 - seq2 phase4 toggle b word8 9:1, bit0 unused
// R14 - phases start at polarity, toggle, repeat
// R15 - words ascend after header; unused bits ignored
`timescale 1ns/1ps
`include "vss_defs.vh"
module vss_vertical_sequence_regs #(
  parameter NSEQ = 3
) (
  input wire clk,
  input wire sys_rst,
  input wire clkEn,
  input wire wordValid,
  input wire [31:0] wordData,
  input wire frameStart,
  input wire asyncUpdateSelect,
  input wire verticalSync,
  input wire [1:0] seqSelect,
  input wire seqRun,
  input wire [3:0] rdWord,
  output reg [31:0] rdData,
  output reg verticalPhaseOne,
  output reg verticalPhaseTwo,
  output reg verticalPhaseThree,
  output reg verticalPhaseFour,
  output reg updatePending
);
  localparam ST_HDR = 2'h0;
  localparam ST_DATA = 2'h1;
  localparam ST_SKIP = 2'h2;

  reg [1:0] state;
  reg [23:0] remain;
  reg countAll;
  reg [3:0] wordIdx;
  reg [255:0] active;
  reg [255:0] pending;
  reg syncPrev;
  reg [8:0] pos;
  reg [35:0] seqNow;

  wire syncFall = syncPrev & ~verticalSync;
  wire dataWrite = clkEn & wordValid & (state == ST_DATA) & (wordIdx <= 4'h8);
  wire [3:0] nextIdx = wordIdx + 4'h1;
  wire [31:0] memRd;
  // mask held as a vector so each word's slice is taken by position, not by shifting
  wire [255:0] writeMask = `VSS_WRITE_MASK;

  // pending image also mirrored in memory; its read output memRd is left unconnected, readback comes from active
  vss_shadow_mem #(.WIDTH(32), .DEPTH(8), .AW(3)) uShadow (
    .clk(clk),
    .clkEn(clkEn),
    .wrEn(dataWrite),
    .wrAddr(wordIdx[2:0] - 3'h1),
    .wrData(wordData),
    .rdAddr(rdWord[2:0] - 3'h1),
    .rdData(memRd)
  );

  // bit position of the msb of word n (1..8) in the packed image
  function [7:0] wordTop;
    input [3:0] n;
    begin
      wordTop = 8'hFF - {n[2:0] - 3'h1, 5'h00};
    end
  endfunction

  // field of 9 bits starting at a packed msb position, crossing words freely
  function [8:0] field9;
    input [255:0] img;
    input [7:0] msb;
    begin
      field9 = img[msb -: 9]; // [R9]
    end
  endfunction

  // sequence layout: len(9), pol(4), then 8 toggles of 9 bits, phase-major
  function [7:0] seqBase;
    input [1:0] s;
    begin
      case (s)
        2'h0: seqBase = 8'hFF;
        2'h1: seqBase = 8'hAA;
        default: seqBase = 8'h55;
      endcase
    end
  endfunction

  // header parse, word counting and pending image update
  always @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_HDR;
      remain <= 24'h000000;
      countAll <= 1'b0;
      wordIdx <= 4'h1;
      pending <= `VSS_RESET_IMAGE;
      active <= `VSS_RESET_IMAGE; // [R6] [R7] [R8] [R10] [R11] [R13]
      updatePending <= 1'b0; // [R1]
      syncPrev <= 1'b0;
    end else if (clkEn) begin
      syncPrev <= verticalSync;
      if (frameStart) begin
        state <= ST_HDR;
      end else if (wordValid) begin
        case (state)
          ST_HDR: begin
            wordIdx <= 4'h1;
            remain <= wordData[`VSS_HDR_CNT_MSB:`VSS_HDR_CNT_LSB]; // [R5]
            countAll <= (wordData[`VSS_HDR_CNT_MSB:`VSS_HDR_CNT_LSB] == 24'h000000); // [R5]
            if (wordData[`VSS_HDR_ADDR_MSB:`VSS_HDR_ADDR_LSB] == `VSS_BANK_ADDR) begin // [R4]
              state <= ST_DATA;
            end else begin
              state <= ST_SKIP;
            end
          end
          ST_DATA: begin
            if (wordIdx <= 4'h8) begin
              // unused bits keep their value [R15]
              pending[wordTop(wordIdx) -: 32] <= (wordData & writeMask[wordTop(wordIdx) -: 32])
                | (pending[wordTop(wordIdx) -: 32] & ~writeMask[wordTop(wordIdx) -: 32]);
            end
            wordIdx <= nextIdx; // [R15]
            if (!countAll) begin
              remain <= remain - 24'h000001;
              if (remain == 24'h000001) begin
                state <= ST_HDR;
              end
            end else if (wordIdx == 4'h8) begin
              state <= ST_HDR;
            end
          end
          default: state <= ST_SKIP;
        endcase
      end
      // held until sync falls unless async update selected
      if (asyncUpdateSelect) begin // [R3]
        active <= pending;
        updatePending <= 1'b0;
      end else if (syncFall && updatePending) begin // [R2]
        active <= pending;
        // a word landing in the same cycle stays pending for the next sync
        updatePending <= dataWrite;
      end else if (dataWrite) begin
        updatePending <= 1'b1; // [R1]
      end
    end
  end

  // snapshot of selected sequence fields
  always @* begin
    seqNow = {field9(active, seqBase(seqSelect)), active[seqBase(seqSelect) - 8'h09 -: 4],
      23'h000000}; // [R12]
  end

  // phase generator: start polarity, invert at toggles, restart at length
  always @(posedge clk) begin
    if (sys_rst) begin
      pos <= 9'h000;
      verticalPhaseOne <= 1'b0;
      verticalPhaseTwo <= 1'b0;
      verticalPhaseThree <= 1'b1;
      verticalPhaseFour <= 1'b1;
      rdData <= 32'h0000_0000;
    end else if (clkEn) begin
      rdData <= (rdWord >= 4'h1 && rdWord <= 4'h8) ? active[wordTop(rdWord) -: 32] : 32'h0000_0000;
      if (!seqRun || pos + 9'h001 >= seqNow[35:27]) begin // [R14]
        pos <= 9'h000;
        verticalPhaseOne <= seqNow[26];
        verticalPhaseTwo <= seqNow[25];
        verticalPhaseThree <= seqNow[24];
        verticalPhaseFour <= seqNow[23];
      end else begin
        pos <= pos + 9'h001;
        // each phase inverts when the count meets one of its toggles [R14] [R8]
        if (pos + 9'h001 == field9(active, seqBase(seqSelect) - 8'h0D)
            || pos + 9'h001 == field9(active, seqBase(seqSelect) - 8'h16)) begin
          verticalPhaseOne <= ~verticalPhaseOne;
        end
        if (pos + 9'h001 == field9(active, seqBase(seqSelect) - 8'h1F)
            || pos + 9'h001 == field9(active, seqBase(seqSelect) - 8'h28)) begin
          verticalPhaseTwo <= ~verticalPhaseTwo;
        end
        if (pos + 9'h001 == field9(active, seqBase(seqSelect) - 8'h31)
            || pos + 9'h001 == field9(active, seqBase(seqSelect) - 8'h3A)) begin
          verticalPhaseThree <= ~verticalPhaseThree;
        end
        if (pos + 9'h001 == field9(active, seqBase(seqSelect) - 8'h43)
            || pos + 9'h001 == field9(active, seqBase(seqSelect) - 8'h4C)) begin
          verticalPhaseFour <= ~verticalPhaseFour;
        end
      end
    end
  end
endmodule // vss_vertical_sequence_regs

// [verif/vss_host_model.sv]
// host model that sends framed words toward the bank
`timescale 1ns/1ps
module vss_host_model (
  input wire clk,
  output reg wordValid,
  output reg [31:0] wordData,
  output reg frameStart
);
  initial begin
    wordValid = 1'b0;
    wordData = 32'h0;
    frameStart = 1'b0;
  end
  // frame boundary: the bank expects a header next
  task start;
    @(negedge clk) frameStart = 1'b1;
    @(negedge clk) frameStart = 1'b0;
  endtask
  // one word per call; idle data is inverted so a stale word never passes
  task word(input [31:0] w);
    @(negedge clk) wordValid = 1'b1;
    wordData = w;
    @(negedge clk) wordValid = 1'b0;
    wordData = ~w;
  endtask
endmodule // vss_host_model

// [verif/vss_regs_chk.sv]
// port assertions of the vertical sequence bank
`timescale 1ns/1ps
module vss_regs_chk (
  input wire clk,
  input wire sys_rst,
  input wire wordValid,
  input wire frameStart,
  input wire asyncUpdateSelect,
  input wire verticalSync,
  input wire [3:0] rdWord,
  input wire [31:0] rdData,
  input wire updatePending
);
  reg vsPrev = 1'b1;
  reg fellSeen = 1'b0;
  // registered sync fall, so a drop of pending can be traced to it
  always @(posedge clk) begin
    vsPrev <= verticalSync;
    fellSeen <= vsPrev & ~verticalSync;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  pend_cause_a: assert property ($rose(updatePending) |-> $past(wordValid) || $past(wordValid, 2))
    else $error("pending rose without a word");
  async_quiet_a: assert property (asyncUpdateSelect && $past(asyncUpdateSelect) && $past(asyncUpdateSelect, 2)
    |-> !updatePending) else $error("pending in async mode");
  fall_apply_a: assert property ($fell(verticalSync) && !wordValid && !asyncUpdateSelect |=> !updatePending)
    else $error("sync fall did not apply");
  pend_keep_a: assert property (updatePending && !$fell(verticalSync) && !asyncUpdateSelect && !frameStart
    |=> updatePending) else $error("pending lost early");
  drop_cause_a: assert property ($fell(updatePending) |-> fellSeen || $past(asyncUpdateSelect))
    else $error("pending dropped without sync");
  rd_none_a: assert property (rdWord == 4'h0 || rdWord > 4'h8 |=> rdData == 32'h0)
    else $error("read of no word not zero");
  unused_bit_a: assert property (rdWord == 4'h8 |=> rdData[0] == 1'b0)
    else $error("unused bit set");
  rd_hold_a: assert property (updatePending && $past(updatePending) && $stable(rdWord) && !asyncUpdateSelect
    && !$past(asyncUpdateSelect) && !$fell(verticalSync) |=> $stable(rdData))
    else $error("active value moved while held");
endmodule // vss_regs_chk
bind vss_vertical_sequence_regs vss_regs_chk chk (.clk(clk), .sys_rst(sys_rst), .wordValid(wordValid),
  .frameStart(frameStart), .asyncUpdateSelect(asyncUpdateSelect), .verticalSync(verticalSync),
  .rdWord(rdWord), .rdData(rdData), .updatePending(updatePending));

// [verif/tb_vss_vertical_sequence_regs.sv]
// self-checking bench of the vertical sequence bank
`timescale 1ns/1ps
module tb_vss_vertical_sequence_regs;
  reg clk = 0;
  reg sys_rst = 1;
  reg asyncUpdateSelect = 0;
  reg verticalSync = 1;
  reg [1:0] seqSelect = 0;
  reg seqRun = 0;
  reg [3:0] rdWord = 1;
  wire wordValid, frameStart, p1, p2, p3, p4, updatePending;
  wire [31:0] wordData, rdData;
  reg [31:0] seed = 32'h4695D054;
  reg [31:0] w1, keep, v;
  integer fail_count = 0, checks = 0, i;
  vss_host_model host (.clk(clk), .wordValid(wordValid), .wordData(wordData), .frameStart(frameStart));
  vss_vertical_sequence_regs dut (.clk(clk), .sys_rst(sys_rst), .clkEn(1'b1), .wordValid(wordValid),
    .wordData(wordData), .frameStart(frameStart), .asyncUpdateSelect(asyncUpdateSelect),
    .verticalSync(verticalSync), .seqSelect(seqSelect), .seqRun(seqRun), .rdWord(rdWord), .rdData(rdData),
    .verticalPhaseOne(p1), .verticalPhaseTwo(p2), .verticalPhaseThree(p3), .verticalPhaseFour(p4),
    .updatePending(updatePending));
  initial forever #5 clk = ~clk;
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("BAD %0s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // readback lands one cycle after the word number
  task rd(input [3:0] n);
    @(negedge clk) rdWord = n;
    seqSelect = {1'b0, seed[0]};
    @(negedge clk) v = rdData;
  endtask
  // header then random words 1..n, count 0 sends the whole bank
  task frame(input [7:0] addr, input [3:0] n);
    host.start();
    host.word({addr, 20'h0, n});
    for (i = 1; i <= (n == 0 ? 8 : n); i = i + 1) begin
      seed = lfsr(seed);
      if (i == 1) w1 = seed;
      host.word(seed);
    end
  endtask
  task complete_run;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 0;
    @(negedge clk) chk("pol0", {p1, p2, p3, p4}, 4'b0011);
    seqRun = 1;
    repeat (18) @(negedge clk);
    chk("ph18", {p1, p2, p3, p4}, 4'b0110);
    @(negedge clk) chk("ph19", {p1, p2, p3, p4}, 4'b1100);
    rd(1); chk("w1rst", v, 32'h1298_0026);
    rd(3); chk("len1", v[10:2], 104);
    rd(4); chk("pol1", v[31:30], 2'b11);
    rd(8); chk("tog2b", v[9:0], 96);
    rd(9); chk("none", v, 0);
    // held write: old values stay active until the sync falls
    frame(8'h14, 2);
    rd(1); chk("w1hold", v, 32'h1298_0026);
    chk("pend", updatePending, 1);
    @(negedge clk) verticalSync = 0;
    rd(1); chk("w1new", v, w1);
    chk("pendclr", updatePending, 0);
    // async: the whole bank applies at once, unused bit stays clear
    asyncUpdateSelect = 1;
    frame(8'h14, 0);
    rd(8); chk("w8", v, seed & 32'hFFFF_FFFE);
    rd(1); chk("w1async", v, w1);
    keep = w1;
    frame(8'h15, 1);
    rd(1); chk("badaddr", v, keep);
    complete_run;
  end
  // the run needs about 90 cycles
  initial begin
    #20000;
    fail_count = fail_count + 1;
    complete_run;
  end
endmodule // tb_vss_vertical_sequence_regs
